/* File: rtl/pbc_phy_regs.sv */
`timescale 1ns/1ps
module pbc_phy_regs #(
  parameter int unsigned PREAMBLE_BITS = pbc_pkg::PREAMBLE_LEN
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] phy_addr,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic negotiation_strap,
  input wire logic speed_strap,
  input wire logic duplex_strap,
  input wire logic fiber_mode_select,
  input wire logic tx_active,
  input wire logic line_collision,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic an_complete,
  input wire logic link_up,
  output logic collision,
  output logic speed_100,
  output logic full_duplex,
  output logic negotiation_enable,
  output logic loopback_enable,
  output logic power_down,
  output logic collision_test_enable
);

  if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 63) begin : g_bad_preamble
    $error("PREAMBLE_BITS must lie between 1 and 63");
  end

  localparam logic [5:0] PRE_TARGET = 6'(PREAMBLE_BITS);

  pbc_pkg::pbc_mdio_state_t state_ff;
  logic mdc_q_ff;
  logic [5:0] pre_cnt_ff;
  logic [3:0] bit_cnt_ff;
  logic [10:0] hdr_ff;
  logic op_wr_ff;
  logic [4:0] reg_idx_ff;
  logic [15:0] sh_ff;
  logic mdio_out_ff;
  logic mdio_oe_ff;
  logic init_done_ff;
  logic speed_select_ff;
  logic negotiation_enable_ff;
  logic duplex_select_ff;
  logic loopback_ff;
  logic power_down_ff;
  logic collision_test_enable_ff;
  logic collision_ff;
  logic speed_100_ff;
  logic full_duplex_ff;

  logic mdc_rise;
  logic [11:0] hdr_word;
  logic hdr_done;
  logic hdr_accept;
  logic [15:0] wr_word;
  logic wr_ctrl;
  logic load_dflt;
  logic [15:0] rd_word;
  logic dflt_speed;
  logic dflt_neg;
  logic dflt_duplex;

  pbc_strap_defaults u_dflt (
    .negotiation_strap(negotiation_strap),
    .speed_strap(speed_strap),
    .duplex_strap(duplex_strap),
    .fiber_mode_select(fiber_mode_select),
    .dflt_speed_select(dflt_speed),
    .dflt_negotiation_enable(dflt_neg),
    .dflt_duplex_select(dflt_duplex)
  );

  // The management clock is slow next to clk and treated as a sampled input, so one stage finds its edge.
  assign mdc_rise = mdc & ~mdc_q_ff;
  assign hdr_word = {hdr_ff, mdio_in};
  assign hdr_done = mdc_rise && (state_ff == pbc_pkg::MD_HDR) && (bit_cnt_ff == pbc_pkg::HDR_LAST);
  assign hdr_accept = (hdr_word[9:5] == phy_addr) &&
                      ((hdr_word[11:10] == pbc_pkg::OP_READ) || (hdr_word[11:10] == pbc_pkg::OP_WRITE));
  assign wr_word = {sh_ff[14:0], mdio_in};
  assign wr_ctrl = mdc_rise && (state_ff == pbc_pkg::MD_DATA) && (bit_cnt_ff == pbc_pkg::DATA_LAST) &&
                   op_wr_ff && (reg_idx_ff == pbc_pkg::CTRL_INDEX);
  // Straps are caught on the first edge after reset release, and again by a soft reset write.
  assign load_dflt = !init_done_ff || (wr_ctrl && wr_word[pbc_pkg::CTRL_SOFT_RST]);

  // Read value for the register addressed by the header now completing.
  always_comb begin
    rd_word = 16'h0000;
    if (hdr_word[4:0] == pbc_pkg::CTRL_INDEX) begin
      rd_word[pbc_pkg::CTRL_LOOPBACK] = loopback_ff;
      rd_word[pbc_pkg::CTRL_SPEED] = speed_select_ff;
      rd_word[pbc_pkg::CTRL_NEG] = negotiation_enable_ff;
      rd_word[pbc_pkg::CTRL_PWRDN] = power_down_ff;
      rd_word[pbc_pkg::CTRL_DUPLEX] = duplex_select_ff;
      rd_word[pbc_pkg::CTRL_COLTEST] = collision_test_enable_ff;
    end else if (hdr_word[4:0] == pbc_pkg::STATUS_INDEX) begin
      rd_word = pbc_pkg::STATUS_FIXED;
      rd_word[pbc_pkg::STATUS_AN_DONE] = an_complete;
      rd_word[pbc_pkg::STATUS_LINK] = link_up;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_q_ff <= 1'b0;
    end else begin
      mdc_q_ff <= mdc;
    end
  end

  // Serial frame engine: preamble, start, op, address, register, turnaround, data.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= pbc_pkg::MD_PRE;
      pre_cnt_ff <= 6'h00;
      bit_cnt_ff <= 4'h0;
      hdr_ff <= 11'h000;
      op_wr_ff <= 1'b0;
      reg_idx_ff <= 5'h00;
      sh_ff <= 16'h0000;
      mdio_out_ff <= 1'b0;
      mdio_oe_ff <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state_ff)
        pbc_pkg::MD_PRE: begin
          if (mdio_in) begin
            if (pre_cnt_ff != PRE_TARGET) begin
              pre_cnt_ff <= pre_cnt_ff + 6'h01;
            end
          end else begin
            pre_cnt_ff <= 6'h00;
            if (pre_cnt_ff == PRE_TARGET) begin
              state_ff <= pbc_pkg::MD_START;
            end
          end
        end
        pbc_pkg::MD_START: begin
          bit_cnt_ff <= 4'h0;
          state_ff <= mdio_in ? pbc_pkg::MD_HDR : pbc_pkg::MD_PRE;
        end
        pbc_pkg::MD_HDR: begin
          hdr_ff <= hdr_word[10:0];
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == pbc_pkg::HDR_LAST) begin
            bit_cnt_ff <= 4'h0;
            if (hdr_accept) begin
              state_ff <= pbc_pkg::MD_TA;
              op_wr_ff <= (hdr_word[11:10] == pbc_pkg::OP_WRITE);
              reg_idx_ff <= hdr_word[4:0];
              sh_ff <= rd_word;
            end else begin
              state_ff <= pbc_pkg::MD_PRE;
            end
          end
        end
        pbc_pkg::MD_TA: begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (!op_wr_ff) begin
            mdio_oe_ff <= 1'b1;
            mdio_out_ff <= (bit_cnt_ff == 4'h0) ? 1'b0 : sh_ff[15];
          end
          if (bit_cnt_ff == pbc_pkg::TA_LAST) begin
            bit_cnt_ff <= 4'h0;
            state_ff <= pbc_pkg::MD_DATA;
            if (!op_wr_ff) begin
              sh_ff <= {sh_ff[14:0], 1'b0};
            end
          end
        end
        pbc_pkg::MD_DATA: begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (op_wr_ff) begin
            sh_ff <= wr_word;
          end else begin
            mdio_out_ff <= sh_ff[15];
            sh_ff <= {sh_ff[14:0], 1'b0};
          end
          if (bit_cnt_ff == pbc_pkg::DATA_LAST) begin
            bit_cnt_ff <= 4'h0;
            mdio_oe_ff <= 1'b0;
            mdio_out_ff <= 1'b0;
            state_ff <= pbc_pkg::MD_PRE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_done_ff <= 1'b0;
    end else begin
      init_done_ff <= 1'b1;
    end
  end

  // Control register. Bits 15, 10, 9 and 6..0 hold nothing and read back as zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_select_ff <= 1'b0;
      negotiation_enable_ff <= 1'b0;
      duplex_select_ff <= 1'b0;
      loopback_ff <= pbc_pkg::CTRL_LOOPBACK_RST;
      power_down_ff <= pbc_pkg::CTRL_PWRDN_RST;
      collision_test_enable_ff <= pbc_pkg::CTRL_COLTEST_RST;
    end else if (load_dflt) begin
      speed_select_ff <= dflt_speed;
      negotiation_enable_ff <= dflt_neg;
      duplex_select_ff <= dflt_duplex;
      loopback_ff <= pbc_pkg::CTRL_LOOPBACK_RST;
      power_down_ff <= pbc_pkg::CTRL_PWRDN_RST;
      collision_test_enable_ff <= pbc_pkg::CTRL_COLTEST_RST;
    end else if (wr_ctrl) begin
      speed_select_ff <= wr_word[pbc_pkg::CTRL_SPEED];
      negotiation_enable_ff <= wr_word[pbc_pkg::CTRL_NEG] & ~fiber_mode_select;
      duplex_select_ff <= wr_word[pbc_pkg::CTRL_DUPLEX];
      loopback_ff <= wr_word[pbc_pkg::CTRL_LOOPBACK];
      power_down_ff <= wr_word[pbc_pkg::CTRL_PWRDN];
      // Collision test is not gated by loopback; keeping it sane is left to software.
      collision_test_enable_ff <= wr_word[pbc_pkg::CTRL_COLTEST];
    end else if (fiber_mode_select) begin
      negotiation_enable_ff <= 1'b0;
    end
  end

  // Operating mode and collision indication seen by the rest of the PHY.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_100_ff <= 1'b0;
      full_duplex_ff <= 1'b0;
      collision_ff <= 1'b0;
    end else begin
      speed_100_ff <= negotiation_enable_ff ? an_speed_100 : speed_select_ff;
      full_duplex_ff <= negotiation_enable_ff ? an_full_duplex : duplex_select_ff;
      collision_ff <= line_collision | (collision_test_enable_ff & tx_active);
    end
  end

  assign mdio_out = mdio_out_ff;
  assign mdio_oe = mdio_oe_ff;
  assign collision = collision_ff;
  assign speed_100 = speed_100_ff;
  assign full_duplex = full_duplex_ff;
  assign negotiation_enable = negotiation_enable_ff;
  assign loopback_enable = loopback_ff;
  assign power_down = power_down_ff;
  assign collision_test_enable = collision_test_enable_ff;

  chk_manual_duplex: assert property (
    @(posedge clk) disable iff (sys_rst)
    !negotiation_enable_ff |=> full_duplex_ff == $past(duplex_select_ff))
    else $error("full duplex output does not follow the duplex select bit");

  chk_collision_test_on: assert property (
    @(posedge clk) disable iff (sys_rst)
    (collision_test_enable_ff && tx_active) |=> collision_ff)
    else $error("collision not shown during transmit in collision test mode");

  chk_collision_test_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!collision_test_enable_ff && !line_collision) |=> !collision_ff)
    else $error("collision shown with test mode off and no line collision");

  chk_speed_reset_value: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(init_done_ff) |->
      speed_select_ff == ($past(fiber_mode_select) || $past(negotiation_strap) || $past(speed_strap)))
    else $error("speed select reset value wrong");

  chk_neg_reset_value: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(init_done_ff) |-> negotiation_enable_ff == ($past(negotiation_strap) && !$past(fiber_mode_select)))
    else $error("negotiation enable reset value wrong");

  chk_duplex_reset_copper: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($rose(init_done_ff) && !$past(fiber_mode_select)) |->
      duplex_select_ff == (!$past(negotiation_strap) && $past(duplex_strap)))
    else $error("duplex reset value wrong outside fiber mode");

  chk_duplex_reset_fiber: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($rose(init_done_ff) && $past(fiber_mode_select)) |-> duplex_select_ff == $past(duplex_strap))
    else $error("duplex reset value wrong in fiber mode");

  chk_status_caps: assert property (
    @(posedge clk) disable iff (sys_rst)
    (hdr_done && hdr_accept && hdr_word[11:10] == pbc_pkg::OP_READ && hdr_word[4:0] == 5'h01) |=>
      sh_ff[15:8] == 8'h78)
    else $error("status capability bits read wrong");

  chk_negotiated_mode: assert property (
    @(posedge clk) disable iff (sys_rst)
    negotiation_enable_ff |=> (speed_100_ff == $past(an_speed_100)) && (full_duplex_ff == $past(an_full_duplex)))
    else $error("negotiated result does not override speed and duplex");

  chk_fiber_forces_neg: assert property (
    @(posedge clk) disable iff (sys_rst)
    fiber_mode_select |=> !negotiation_enable_ff)
    else $error("negotiation enable not forced low in fiber mode");

  chk_ctrl_reserved_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    (hdr_done && hdr_accept && hdr_word[4:0] == pbc_pkg::CTRL_INDEX) |=> sh_ff[6:0] == 7'h00)
    else $error("reserved control bits not read as zero");

  chk_mdio_release: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mdc_rise && state_ff == pbc_pkg::MD_DATA && bit_cnt_ff == pbc_pkg::DATA_LAST) |=> !mdio_oe_ff)
    else $error("data line not released after the last data bit");

endmodule

/* File: rtl/pbc_pkg.sv */
package pbc_pkg;

  // Management register indices on the serial management interface.
  localparam logic [4:0] CTRL_INDEX = 5'h00;
  localparam logic [4:0] STATUS_INDEX = 5'h01;

  // Frame fields.
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int unsigned PREAMBLE_LEN = 32;
  localparam logic [3:0] HDR_LAST = 4'hB;
  localparam logic [3:0] TA_LAST = 4'h1;
  localparam logic [3:0] DATA_LAST = 4'hF;

  // Control register bit positions.
  localparam int unsigned CTRL_SOFT_RST = 15;
  localparam int unsigned CTRL_LOOPBACK = 14;
  localparam int unsigned CTRL_SPEED = 13;
  localparam int unsigned CTRL_NEG = 12;
  localparam int unsigned CTRL_PWRDN = 11;
  localparam int unsigned CTRL_DUPLEX = 8;
  localparam int unsigned CTRL_COLTEST = 7;

  // Values after reset of the control bits that do not come from straps.
  localparam logic CTRL_LOOPBACK_RST = 1'b0;
  localparam logic CTRL_PWRDN_RST = 1'b0;
  localparam logic CTRL_COLTEST_RST = 1'b0;

  // Fixed status bits: capabilities 14..11, negotiation ability 3, extended capability 0.
  localparam logic [15:0] STATUS_FIXED = 16'h7809;
  localparam int unsigned STATUS_AN_DONE = 5;
  localparam int unsigned STATUS_LINK = 2;

  typedef enum logic [2:0] {
    MD_PRE,
    MD_START,
    MD_HDR,
    MD_TA,
    MD_DATA
  } pbc_mdio_state_t;

endpackage

/* File: rtl/pbc_strap_defaults.sv */
`timescale 1ns/1ps
module pbc_strap_defaults (
  input wire logic negotiation_strap,
  input wire logic speed_strap,
  input wire logic duplex_strap,
  input wire logic fiber_mode_select,
  output logic dflt_speed_select,
  output logic dflt_negotiation_enable,
  output logic dflt_duplex_select
);

  assign dflt_speed_select = fiber_mode_select | negotiation_strap | speed_strap;
  assign dflt_negotiation_enable = negotiation_strap & ~fiber_mode_select;
  // In fiber mode the negotiation strap has no say over duplex.
  assign dflt_duplex_select = fiber_mode_select ? duplex_strap : (~negotiation_strap & duplex_strap);

endmodule

/* File: verif/pbc_mgmt_host.sv */
`timescale 1ns/1ps
module pbc_mgmt_host #(
  parameter int unsigned PRE = 4
) (
  input wire logic clk,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_in
);
  logic drv_en;
  logic drv_bit;
  initial begin
    mdc = 1'h0;
    drv_en = 1'h0;
    drv_bit = 1'h1;
  end
  // The data line has a pull-up, so a released line reads 1 rather than the last value.
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_bit : 1'h1);
  // Data changes while the clock is low; the line is sampled late in the high phase.
  // By then the device has settled the bit that it launched at this rise.
  task automatic bit_cycle(input logic en, input logic b, output logic seen);
    drv_en <= en;
    drv_bit <= b;
    mdc <= 1'h0;
    repeat (4) @(posedge clk);
    mdc <= 1'h1;
    repeat (4) @(posedge clk);
    seen = mdio_in;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] adr, input logic [4:0] idx,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic wr;
    hdr = {2'h1, op, adr, idx};
    wr = (op == pbc_pkg::OP_WRITE);
    rd = 16'h0000;
    for (int i = 0; i < PRE; i++) bit_cycle(1'h1, 1'h1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'h1, hdr[i], s);
    bit_cycle(wr, 1'h1, s);
    bit_cycle(wr, 1'h0, s);
    // The device launches bit 15 at the second turnaround rise, so read data runs one rise ahead of the data phase.
    rd[15] = s;
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(wr, wd[i], s);
      if (i > 0) begin
        rd[i - 1] = s;
      end
    end
    bit_cycle(1'h0, 1'h1, s);
    // The management clock stands still low between frames.
    drv_en <= 1'h0;
    mdc <= 1'h0;
    @(posedge clk);
  endtask
endmodule

/* File: verif/pbc_phy_regs_tb.sv */
`timescale 1ns/1ps
module pbc_phy_regs_tb;
  localparam int unsigned PRE = 4;
  localparam logic [4:0] MY_ADDR = 5'h05;
  logic clk, sys_rst, mdc, mdio_in, mdio_out, mdio_oe;
  logic negotiation_strap, speed_strap, duplex_strap, fiber_mode_select;
  logic tx_active, line_collision, an_speed_100, an_full_duplex, an_complete, link_up;
  logic collision, speed_100, full_duplex, negotiation_enable, loopback_enable, power_down, collision_test_enable;
  int err_count;
  int checks_done;
  logic [31:0] rng;
  logic [15:0] rd;
  logic [15:0] wd;

  pbc_phy_regs #(.PREAMBLE_BITS(PRE)) pbc_phy_regs_inst (
    .clk, .sys_rst, .phy_addr(MY_ADDR), .mdc, .mdio_in, .mdio_out, .mdio_oe,
    .negotiation_strap, .speed_strap, .duplex_strap, .fiber_mode_select, .tx_active, .line_collision,
    .an_speed_100, .an_full_duplex, .an_complete, .link_up, .collision, .speed_100, .full_duplex,
    .negotiation_enable, .loopback_enable, .power_down, .collision_test_enable
  );
  pbc_mgmt_host #(.PRE(PRE)) pbc_mgmt_host_inst (.clk, .mdio_out, .mdio_oe, .mdc, .mdio_in);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] exp_status(input logic anc, input logic lnk);
    return {8'h78, 2'h0, anc, 1'h0, 1'h1, lnk, 1'h0, 1'h1};
  endfunction
  function automatic logic [15:0] exp_ctrl_rst(input logic neg, input logic spd, input logic dup, input logic fib);
    logic [15:0] v;
    v = 16'h0000;
    v[13] = fib | neg | spd;
    v[12] = neg & ~fib;
    v[8] = fib ? dup : (~neg & dup);
    return v;
  endfunction

  task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp1(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] idx, input logic [15:0] w);
    pbc_mgmt_host_inst.frame(op, MY_ADDR, idx, w, rd);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // A hung run is cut short and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("[FAIL] run length expected below 100000 cycles seen limit reached");
    summarize();
  end

  initial begin
    sys_rst = 1'h1;
    {negotiation_strap, speed_strap, duplex_strap, fiber_mode_select} = 4'h0;
    {tx_active, line_collision, an_speed_100, an_full_duplex, an_complete, link_up} = 6'h00;
    err_count = 0;
    checks_done = 0;
    rng = 32'h00010E01;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 16; k++) begin
      {fiber_mode_select, negotiation_strap, speed_strap, duplex_strap} <= k[3:0];
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      repeat (3) @(posedge clk);
      xfer(pbc_pkg::OP_READ, pbc_pkg::CTRL_INDEX, 16'h0000);
      cmp16("ctrl_default", exp_ctrl_rst(k[2], k[1], k[0], k[3]), rd);
      cmp1("neg_enable_default", k[2] & ~k[3], negotiation_enable);
    end
    $display("strap defaults done");
    fiber_mode_select <= 1'h0;
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      an_complete <= rng[0];
      link_up <= rng[1];
      xfer(pbc_pkg::OP_WRITE, pbc_pkg::STATUS_INDEX, rng[31:16]);
      xfer(pbc_pkg::OP_READ, pbc_pkg::STATUS_INDEX, 16'h0000);
      cmp16("status", exp_status(rng[0], rng[1]), rd);
    end
    $display("status read done");
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      // Soft reset and negotiation stay clear so the written mode is what shows.
      wd = (k == 0) ? 16'h01FF : (rng[15:0] & 16'h6FFF);
      xfer(pbc_pkg::OP_WRITE, pbc_pkg::CTRL_INDEX, wd);
      xfer(pbc_pkg::OP_READ, pbc_pkg::CTRL_INDEX, 16'h0000);
      cmp16("ctrl_readback", wd & 16'h6980, rd);
      cmp1("full_duplex", wd[8], full_duplex);
      cmp1("speed_100", wd[13], speed_100);
      cmp1("coll_test_enable", wd[7], collision_test_enable);
      cmp1("loopback_enable", wd[14], loopback_enable);
      cmp1("power_down", wd[11], power_down);
    end
    // A soft reset reloads the strap defaults and drops the other bits of the same word.
    xfer(pbc_pkg::OP_WRITE, pbc_pkg::CTRL_INDEX, 16'hC980);
    xfer(pbc_pkg::OP_READ, pbc_pkg::CTRL_INDEX, 16'h0000);
    cmp16("soft_reset", exp_ctrl_rst(negotiation_strap, speed_strap, duplex_strap, fiber_mode_select), rd);
    $display("control write done");
    xfer(pbc_pkg::OP_WRITE, pbc_pkg::CTRL_INDEX, 16'h1000);
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      an_speed_100 <= rng[0];
      an_full_duplex <= rng[1];
      repeat (3) @(posedge clk);
      cmp1("neg_full_duplex", rng[1], full_duplex);
      cmp1("neg_speed_100", rng[0], speed_100);
    end
    fiber_mode_select <= 1'h1;
    repeat (3) @(posedge clk);
    cmp1("fiber_neg_enable", 1'h0, negotiation_enable);
    fiber_mode_select <= 1'h0;
    $display("negotiation done");
    xfer(pbc_pkg::OP_WRITE, pbc_pkg::CTRL_INDEX, 16'h4080);
    tx_active <= 1'h1;
    repeat (3) @(posedge clk);
    cmp1("coll_test_tx", 1'h1, collision);
    tx_active <= 1'h0;
    repeat (3) @(posedge clk);
    cmp1("coll_test_idle", 1'h0, collision);
    xfer(pbc_pkg::OP_WRITE, pbc_pkg::CTRL_INDEX, 16'h4000);
    tx_active <= 1'h1;
    repeat (3) @(posedge clk);
    cmp1("coll_test_off", 1'h0, collision);
    tx_active <= 1'h0;
    pbc_mgmt_host_inst.frame(pbc_pkg::OP_READ, MY_ADDR ^ 5'h01, pbc_pkg::STATUS_INDEX, 16'h0000, rd);
    cmp16("foreign_addr", 16'hFFFF, rd);
    pbc_mgmt_host_inst.frame(2'h3, MY_ADDR, pbc_pkg::STATUS_INDEX, 16'h0000, rd);
    cmp16("illegal_op", 16'hFFFF, rd);
    $display("collision test done");
    summarize();
  end
endmodule
